// ---- common/timer_event_counter_16bit_defines.vh ----
/*
 * Constants for the 16-bit timer / event counter: register offsets,
 * field positions, reset values, mode codes and the full count.
 * Assumes it is included by bare name from the rtl files.
 */
//
// Notes on behaviour
// - modes high=0 low=1 select event counting
// - event counting advances only while run set
// - polarity low rising, high falling edges count
// - overflow reloads preload and keeps counting
// - overflow sets flag; irq only when enabled
// - enable low means no interrupt signal
// - both mode bits high select pulse width
// - polarity low: count falling edge to high
// - polarity high: count rising edge to low
// - pulse end clears run; count stays readable
// - after pulse end, pin ignored until run
// - pulse counting starts on edges, not levels
// - timer mode counts the system clock
// - pin events counted at the fourth timer clock
// - count read or preload write inhibits counting
// - overflow never wakes from power down
// - run bit is control bit 4
// - modes high=1 low=0 select timer mode
// - full count ffff; stopped preload loads counter
// - low byte buffered until high byte write
// - edge polarity is control bit 3
`ifndef TIMER_EVENT_COUNTER_16BIT_DEFINES_VH
`define TIMER_EVENT_COUNTER_16BIT_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        5'h00
`define OFS_COUNT_LOW   5'h04
`define OFS_COUNT_HIGH  5'h08
`define OFS_INTC        5'h0C
`define OFS_PORT_A_DIR  5'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_MODE_HIGH   7
`define BIT_MODE_LOW    6
`define BIT_RUN         4
`define BIT_EDGE_POL    3
`define BIT_IRQ_EN      0
`define BIT_IRQ_FLAG    1
`define BIT_PIN_DIR     2

// ----------------------------------------------------------------
// mode codes {high, low}
// ----------------------------------------------------------------
`define MODE_IDLE       2'h0
`define MODE_EVENT      2'h1
`define MODE_TIMER      2'h2
`define MODE_PULSE      2'h3

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_CTRL        8'h00
`define RST_COUNT       16'h0000
`define RST_PORT_A_DIR  8'hFF
`define FULL_COUNT      16'hFFFF
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ---- rtl/pin_sync_edge.v ----
/*
 * Two-stage synchroniser and edge detector for the timer input pin.
 * Assumes the pin is asynchronous to i_clk_sys and idles high.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_sync_edge (
    input  wire i_clk_sys,
    input  wire i_nrst,
    input  wire i_clk_en,
    input  wire i_pin,
    output reg  o_rise,
    output reg  o_fall
);

    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    // ----------------------------------------------------------------
    // synchroniser; only sync_reg reads meta_reg
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
            o_rise   <= 1'b0;
            o_fall   <= 1'b0;
        end else if (i_clk_en) begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            o_rise   <= sync_reg & ~last_reg;
            o_fall   <= ~sync_reg & last_reg;
        end
    end

endmodule // pin_sync_edge

`default_nettype wire

// ---- rtl/timer_event_counter_16bit.v ----
/*
 * 16-bit count-up timer / event counter with preload, three modes
 * and an AXI4-Lite register slave.
 * Assumes one clock, the timer pin asynchronous, one AXI master.
 */
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_counter_16bit_defines.vh"

module timer_event_counter_16bit #(
    parameter ADDR_W = 5
) (
    input  wire              i_clk_sys,
    input  wire              i_nrst,
    input  wire              i_clk_en,
    input  wire              i_timer_input_pin,
    input  wire              i_power_down,
    input  wire [ADDR_W-1:0] i_s_axi_awaddr,
    input  wire              i_s_axi_awvalid,
    output reg               o_s_axi_awready,
    input  wire [31:0]       i_s_axi_wdata,
    input  wire [3:0]        i_s_axi_wstrb,
    input  wire              i_s_axi_wvalid,
    output reg               o_s_axi_wready,
    output reg  [1:0]        o_s_axi_bresp,
    output reg               o_s_axi_bvalid,
    input  wire              i_s_axi_bready,
    input  wire [ADDR_W-1:0] i_s_axi_araddr,
    input  wire              i_s_axi_arvalid,
    output reg               o_s_axi_arready,
    output reg  [31:0]       o_s_axi_rdata,
    output reg  [1:0]        o_s_axi_rresp,
    output reg               o_s_axi_rvalid,
    input  wire              i_s_axi_rready,
    output reg               o_timer_irq,
    output reg               o_count_run,
    output reg               o_timer_pin_is_input
);

    localparam PW_WAIT  = 1'b0;
    localparam PW_COUNT = 1'b1;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function is_mapped;
        input [ADDR_W-1:0] addr;
        begin
            is_mapped = (addr == `OFS_CTRL) || (addr == `OFS_COUNT_LOW) ||
                        (addr == `OFS_COUNT_HIGH) || (addr == `OFS_INTC) ||
                        (addr == `OFS_PORT_A_DIR);
        end
    endfunction

    reg  [ADDR_W-1:0] awaddr_reg;
    reg  [31:0]       wdata_reg;
    reg               wstrb0_reg;
    reg               aw_full_reg;
    reg               w_full_reg;
    reg  [1:0]        mode_reg;
    reg               edge_polarity_bit_reg;
    reg               irq_enable_reg;
    reg               irq_flag_reg;
    reg  [7:0]        port_a_direction_reg;
    reg  [7:0]        low_buf_reg;
    reg  [7:0]        low_read_reg;
    reg  [15:0]       preload_reg;
    reg  [15:0]       count_reg;
    reg               pw_state_reg;

    reg  [15:0]       preload_next;
    reg  [15:0]       count_next;
    reg               run_next;
    reg               pw_state_next;
    reg               irq_flag_next;
    reg  [31:0]       rdata_next;
    reg               tick;
    reg               stop_pulse;

    wire              pin_rise;
    wire              pin_fall;
    wire              wr_en;
    wire              rd_en;
    wire              wr_byte;
    wire              wr_ctrl;
    wire              wr_high;
    wire              rd_count;
    wire              inhibit;
    wire              count_edge;
    wire              start_edge;
    wire              end_edge;
    wire              overflow;

    // ----------------------------------------------------------------
    // timer input pin
    // ----------------------------------------------------------------
    pin_sync_edge u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_clk_en  (i_clk_en),
        .i_pin     (i_timer_input_pin),
        .o_rise    (pin_rise),
        .o_fall    (pin_fall)
    );

    // ----------------------------------------------------------------
    // bus strobes
    // ----------------------------------------------------------------
    // a write commits once address and data are both held
    assign wr_en    = aw_full_reg & w_full_reg & ~o_s_axi_bvalid;
    assign rd_en    = i_s_axi_arvalid & o_s_axi_arready;
    assign wr_byte  = wr_en & wstrb0_reg;
    assign wr_ctrl  = wr_byte & (awaddr_reg == `OFS_CTRL);
    assign wr_high  = wr_byte & (awaddr_reg == `OFS_COUNT_HIGH);
    assign rd_count = rd_en & ((i_s_axi_araddr == `OFS_COUNT_HIGH) ||
                               (i_s_axi_araddr == `OFS_COUNT_LOW));
    // the count is frozen for the access cycle; an edge then is lost
    assign inhibit  = rd_count | wr_high;

    // ----------------------------------------------------------------
    // edge selection
    // ----------------------------------------------------------------
    assign count_edge = edge_polarity_bit_reg ? pin_fall : pin_rise;
    assign start_edge = edge_polarity_bit_reg ? pin_rise : pin_fall;
    assign end_edge   = edge_polarity_bit_reg ? pin_fall : pin_rise;
    assign overflow   = tick & (count_reg == `FULL_COUNT);

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    always @* begin
        tick          = 1'b0;
        stop_pulse    = 1'b0;
        pw_state_next = pw_state_reg;
        if (o_count_run && !i_power_down && !inhibit) begin
            case (mode_reg)
                `MODE_TIMER: tick = 1'b1;
                `MODE_EVENT: tick = count_edge;
                `MODE_PULSE: begin
                    if (pw_state_reg == PW_COUNT) begin
                        if (end_edge) begin
                            stop_pulse    = 1'b1;
                            pw_state_next = PW_WAIT;
                        end else begin
                            tick = 1'b1;
                        end
                    end else if (start_edge) begin
                        pw_state_next = PW_COUNT;
                    end
                end
                default: tick = 1'b0;
            endcase
        end
        if (!o_count_run || mode_reg != `MODE_PULSE) begin
            pw_state_next = PW_WAIT;
        end
    end

    always @* begin
        preload_next = preload_reg;
        if (wr_high) begin
            preload_next = {wdata_reg[7:0], low_buf_reg};
        end
        count_next = count_reg;
        if (overflow) begin
            count_next = preload_reg;
        end else if (tick) begin
            count_next = count_reg + 16'h0001;
        end
        if (wr_high && !o_count_run) begin
            count_next = preload_next;
        end
        run_next = o_count_run;
        if (stop_pulse) begin
            run_next = 1'b0;
        end
        if (wr_ctrl) begin
            run_next = wdata_reg[`BIT_RUN];
        end
        irq_flag_next = irq_flag_reg;
        if (wr_byte && awaddr_reg == `OFS_INTC) begin
            irq_flag_next = wdata_reg[`BIT_IRQ_FLAG];
        end
        // a new overflow beats a clear in the same cycle
        if (overflow) begin
            irq_flag_next = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        case (i_s_axi_araddr)
            `OFS_CTRL: begin
                rdata_next[`BIT_MODE_HIGH] = mode_reg[1];
                rdata_next[`BIT_MODE_LOW]  = mode_reg[0];
                rdata_next[`BIT_RUN]       = o_count_run;
                rdata_next[`BIT_EDGE_POL]  = edge_polarity_bit_reg;
            end
            `OFS_COUNT_LOW:  rdata_next[7:0] = low_read_reg;
            `OFS_COUNT_HIGH: rdata_next[7:0] = count_reg[15:8];
            `OFS_INTC: begin
                rdata_next[`BIT_IRQ_EN]   = irq_enable_reg;
                rdata_next[`BIT_IRQ_FLAG] = irq_flag_reg;
            end
            `OFS_PORT_A_DIR: rdata_next[7:0] = port_a_direction_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_bresp   <= `RESP_OKAY;
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_rresp   <= `RESP_OKAY;
            o_s_axi_rdata   <= 32'h00000000;
            awaddr_reg      <= {ADDR_W{1'b0}};
            wdata_reg       <= 32'h00000000;
            wstrb0_reg      <= 1'b0;
            aw_full_reg     <= 1'b0;
            w_full_reg      <= 1'b0;
        end else if (i_clk_en) begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                awaddr_reg      <= i_s_axi_awaddr;
                aw_full_reg     <= 1'b1;
                o_s_axi_awready <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                wdata_reg      <= i_s_axi_wdata;
                wstrb0_reg     <= i_s_axi_wstrb[0];
                w_full_reg     <= 1'b1;
                o_s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                aw_full_reg    <= 1'b0;
                w_full_reg     <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= is_mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid  <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready  <= 1'b1;
            end
            if (rd_en) begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid  <= 1'b1;
                o_s_axi_rdata   <= rdata_next;
                o_s_axi_rresp   <= is_mapped(i_s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid  <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // timer state and registers
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_reg              <= `MODE_IDLE;
            edge_polarity_bit_reg <= 1'b0;
            o_count_run           <= 1'b0;
            irq_enable_reg        <= 1'b0;
            irq_flag_reg          <= 1'b0;
            port_a_direction_reg  <= `RST_PORT_A_DIR;
            low_buf_reg           <= 8'h00;
            low_read_reg          <= 8'h00;
            preload_reg           <= `RST_COUNT;
            count_reg             <= `RST_COUNT;
            pw_state_reg          <= PW_WAIT;
            o_timer_irq           <= 1'b0;
            o_timer_pin_is_input  <= 1'b1;
        end else if (i_clk_en) begin
            if (wr_ctrl) begin
                mode_reg              <= {wdata_reg[`BIT_MODE_HIGH],
                                          wdata_reg[`BIT_MODE_LOW]};
                edge_polarity_bit_reg <= wdata_reg[`BIT_EDGE_POL];
            end
            if (wr_byte && awaddr_reg == `OFS_INTC) begin
                irq_enable_reg <= wdata_reg[`BIT_IRQ_EN];
            end
            if (wr_byte && awaddr_reg == `OFS_PORT_A_DIR) begin
                port_a_direction_reg <= wdata_reg[7:0];
            end
            if (wr_byte && awaddr_reg == `OFS_COUNT_LOW) begin
                low_buf_reg <= wdata_reg[7:0];
            end
            if (rd_en && i_s_axi_araddr == `OFS_COUNT_HIGH) begin
                low_read_reg <= count_reg[7:0];
            end
            o_count_run   <= run_next;
            preload_reg   <= preload_next;
            count_reg     <= count_next;
            pw_state_reg  <= pw_state_next;
            irq_flag_reg  <= irq_flag_next;
            // no wake output exists, so overflow cannot leave power down
            o_timer_irq   <= irq_flag_reg & irq_enable_reg;
            o_timer_pin_is_input <= port_a_direction_reg[`BIT_PIN_DIR];
        end
    end

endmodule // timer_event_counter_16bit

`default_nettype wire

// ---- verif/timer_event_counter_16bit_props.sv ----
/*
 * Concurrent checks on the timer block's top ports: bus handshakes,
 * reset values and what may move the run and pin-direction outputs.
 * Assumes one clock domain and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_event_counter_16bit_props #(
    parameter ADDR_W = 5
) (
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    input wire logic        i_clk_en,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic        o_timer_irq,
    input wire logic        o_count_run,
    input wire logic        o_timer_pin_is_input
);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_write_gets_resp: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
        && o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("write response late");
    a_bresp_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready
        |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
    a_write_busy: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken while response pending");
    a_read_gets_data: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
    a_read_busy: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read taken while data pending");
    a_reset_outputs: assert property ($rose(i_nrst) |-> o_timer_pin_is_input
        && !o_count_run && !o_timer_irq) else $error("outputs wrong after reset");
    a_run_set_by_bus: assert property ($rose(o_count_run) |-> o_s_axi_bvalid
        || $past(o_s_axi_bvalid)) else $error("run rose without a write");
    a_pin_dir_by_bus: assert property ($changed(o_timer_pin_is_input)
        |-> $past(o_s_axi_bvalid) || $past(o_s_axi_bvalid, 2)) else $error("pin dir moved");
    // a frozen clock enable must hold the run and irq outputs
    a_enable_freezes: assert property (!i_clk_en [*2] |=> $stable(o_count_run)
        && $stable(o_timer_irq)) else $error("state moved while disabled");
endmodule // timer_event_counter_16bit_props

bind timer_event_counter_16bit timer_event_counter_16bit_props #(.ADDR_W(ADDR_W)) u_props (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .o_timer_irq(o_timer_irq), .o_count_run(o_count_run),
    .o_timer_pin_is_input(o_timer_pin_is_input));
`default_nettype wire

// ---- verif/pin_source.sv ----
/*
 * External pulse / event source on the timer input pin.
 * Assumes the pin is pulled high when idle; levels change after a clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_source (
    input  wire logic i_clk_sys,
    output var  logic o_pin
);
    initial o_pin = 1'b1;
    // set a level and hold it n clocks; callers return the pin high at the end
    task automatic drv(input logic lvl, input int n);
        @(posedge i_clk_sys);
        o_pin <= lvl;
        repeat (n) @(posedge i_clk_sys);
    endtask
    // low pulses: each gives one fall and one rise, wide enough for the synchroniser
    task automatic pulses(input int k);
        repeat (k) begin
            drv(1'b0, 4);
            drv(1'b1, 4);
        end
    endtask
endmodule // pin_source
`default_nettype wire

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench: AXI4-Lite register tasks and mode scenarios.
 * Assumes pin_source as the pin partner and the bound props checker.
 */
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_counter_16bit_defines.vh"
module tb_top;
    logic        i_clk_sys = 1'b0, i_nrst = 1'b0, clk_en = 1'b1, pwr_dn = 1'b0;
    logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
    logic        ar_valid = 1'b0, r_ready = 1'b0;
    logic [4:0]  aw_addr = 5'h00, ar_addr = 5'h00;
    logic [31:0] w_data = 32'h0;
    logic [3:0]  w_strb = 4'hF;
    wire logic   pin, aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, irq, run, pin_in;
    wire logic [1:0]  b_resp, r_resp;
    wire logic [31:0] r_data;
    int n_fail = 0;
    int n_checks = 0;

    initial forever #10 i_clk_sys = ~i_clk_sys;

    timer_event_counter_16bit #(.ADDR_W(5)) u_timer_event_counter_16bit (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_clk_en(clk_en),
        .i_timer_input_pin(pin), .i_power_down(pwr_dn),
        .i_s_axi_awaddr(aw_addr), .i_s_axi_awvalid(aw_valid), .o_s_axi_awready(aw_rdy),
        .i_s_axi_wdata(w_data), .i_s_axi_wstrb(w_strb), .i_s_axi_wvalid(w_valid),
        .o_s_axi_wready(w_rdy), .o_s_axi_bresp(b_resp), .o_s_axi_bvalid(b_valid),
        .i_s_axi_bready(b_ready), .i_s_axi_araddr(ar_addr), .i_s_axi_arvalid(ar_valid),
        .o_s_axi_arready(ar_rdy), .o_s_axi_rdata(r_data), .o_s_axi_rresp(r_resp),
        .o_s_axi_rvalid(r_valid), .i_s_axi_rready(r_ready), .o_timer_irq(irq),
        .o_count_run(run), .o_timer_pin_is_input(pin_in));
    pin_source u_pin_source (.i_clk_sys(i_clk_sys), .o_pin(pin));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ready is raised only after valid is seen, so the hold paths get used
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF, input logic [1:0] er = 2'h0);
        aw_addr <= a;
        w_data <= d;
        w_strb <= s;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        fork
            begin do @(posedge i_clk_sys); while (!aw_rdy); aw_valid <= 1'b0; end
            begin do @(posedge i_clk_sys); while (!w_rdy); w_valid <= 1'b0; end
        join
        do @(posedge i_clk_sys); while (!b_valid);
        b_ready <= 1'b1;
        @(posedge i_clk_sys);
        b_ready <= 1'b0;
        chk("bresp", b_resp, er);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
        ar_addr <= a;
        ar_valid <= 1'b1;
        do @(posedge i_clk_sys); while (!ar_rdy);
        ar_valid <= 1'b0;
        do @(posedge i_clk_sys); while (!r_valid);
        r_ready <= 1'b1;
        @(posedge i_clk_sys);
        r_ready <= 1'b0;
        d = r_data;
        chk("rresp", r_resp, er);
    endtask
    // high read latches the low byte, so it must come first
    task automatic rdcnt(output logic [15:0] c);
        logic [31:0] h, l;
        rd(`OFS_COUNT_HIGH, h);
        rd(`OFS_COUNT_LOW, l);
        c = {h[7:0], l[7:0]};
    endtask
    task automatic wrcnt(input logic [15:0] c);
        wr(`OFS_COUNT_LOW, {24'h0, c[7:0]});
        wr(`OFS_COUNT_HIGH, {24'h0, c[15:8]});
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic r, input logic p);
        return {24'h0, m, 1'b0, r, p, 3'h0};
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_fail++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [15:0] c, c2;
        repeat (12) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        @(posedge i_clk_sys);
        rd(`OFS_CTRL, d);
        chk("ctrl", d, 32'h0);
        rd(`OFS_PORT_A_DIR, d);
        chk("dir", d, 32'hFF);
        rd(5'h14, d, `RESP_SLVERR);
        chk("unmapped", d, 32'h0);
        wr(`OFS_PORT_A_DIR, 32'hFB, 4'h0);
        chk("pin_in", pin_in, 1'b1);
        wr(`OFS_PORT_A_DIR, 32'hFB);
        chk("pin_in", pin_in, 1'b0);
        wr(`OFS_PORT_A_DIR, 32'hFF);
        wrcnt(16'h12AB);
        rdcnt(c);
        chk("count", c, 16'h12AB);
        wr(`OFS_COUNT_LOW, 32'h56);
        rdcnt(c);
        chk("count", c, 16'h12AB);
        wr(`OFS_COUNT_HIGH, 32'h34);
        rdcnt(c);
        chk("count", c, 16'h3456);
        // timer mode, overflow, interrupt gating, preload while running
        wrcnt(16'hFF00);
        wr(`OFS_CTRL, ctl(2'h2, 1'b0, 1'b0));
        wr(`OFS_CTRL, ctl(2'h2, 1'b1, 1'b0));
        chk("run", run, 1'b1);
        rdcnt(c);
        chk("cnt_hi", c[15:8], 8'hFF);
        repeat (300) @(posedge i_clk_sys);
        chk("irq_off", irq, 1'b0);
        rd(`OFS_INTC, d);
        chk("flag", d[1], 1'b1);
        wr(`OFS_INTC, 32'h3);
        chk("irq_on", irq, 1'b1);
        wrcnt(16'h1000);
        rdcnt(c);
        chk("cnt_hi", c[15:8], 8'hFF);
        repeat (300) @(posedge i_clk_sys);
        rdcnt(c);
        chk("reload", c[15:8], 8'h10);
        pwr_dn <= 1'b1;
        rdcnt(c);
        repeat (20) @(posedge i_clk_sys);
        rdcnt(c2);
        chk("pwr_dn", c2, c);
        pwr_dn <= 1'b0;
        clk_en <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        clk_en <= 1'b1;
        wr(`OFS_CTRL, ctl(2'h2, 1'b0, 1'b0));
        wr(`OFS_INTC, 32'h0);
        chk("irq_clr", irq, 1'b0);
        rdcnt(c);
        rdcnt(c2);
        chk("stopped", c2, c);
        // mode 00 must not count even with run set
        wr(`OFS_CTRL, ctl(2'h0, 1'b0, 1'b0));
        wr(`OFS_CTRL, ctl(2'h0, 1'b1, 1'b0));
        rdcnt(c2);
        chk("idle_mode", c2, c);
        wr(`OFS_CTRL, ctl(2'h0, 1'b0, 1'b0));
        // event counting, both polarities, overflow reload
        wrcnt(16'hFFFD);
        wr(`OFS_CTRL, ctl(2'h1, 1'b0, 1'b0));
        u_pin_source.pulses(3);
        rdcnt(c);
        chk("ev_idle", c, 16'hFFFD);
        wr(`OFS_CTRL, ctl(2'h1, 1'b1, 1'b0));
        u_pin_source.pulses(4);
        rdcnt(c);
        chk("ev_rise", c, 16'hFFFE);
        rd(`OFS_INTC, d);
        chk("ev_flag", d[1], 1'b1);
        wr(`OFS_CTRL, ctl(2'h1, 1'b0, 1'b1));
        wrcnt(16'h0000);
        wr(`OFS_CTRL, ctl(2'h1, 1'b1, 1'b1));
        u_pin_source.pulses(3);
        rdcnt(c);
        chk("ev_fall", c, 16'h0003);
        // pulse width: a 21-clock pulse counts 20, both edges seen late alike
        wr(`OFS_CTRL, ctl(2'h3, 1'b0, 1'b0));
        wrcnt(16'h0000);
        wr(`OFS_CTRL, ctl(2'h3, 1'b1, 1'b0));
        u_pin_source.drv(1'b0, 20);
        u_pin_source.drv(1'b1, 6);
        chk("pw_run", run, 1'b0);
        u_pin_source.pulses(2);
        rdcnt(c);
        chk("pw_low", c, 16'h0014);
        wr(`OFS_CTRL, ctl(2'h3, 1'b0, 1'b1));
        wrcnt(16'h0000);
        wr(`OFS_CTRL, ctl(2'h3, 1'b1, 1'b1));
        repeat (10) @(posedge i_clk_sys);
        rdcnt(c);
        chk("pw_level", c, 16'h0000);
        u_pin_source.drv(1'b0, 6);
        u_pin_source.drv(1'b1, 20);
        u_pin_source.drv(1'b0, 6);
        u_pin_source.drv(1'b1, 6);
        rdcnt(c);
        chk("pw_high", c, 16'h0014);
        chk("pw_run", run, 1'b0);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
